// File: rtl/t1pwm_cfg.svh
// register offsets, field positions and reset values of the timer/pulse/buzzer block
`ifndef T1PWM_CFG_SVH
`define T1PWM_CFG_SVH

// register offsets
`define T1PWM_ADDR_COUNT   4'h0
`define T1PWM_ADDR_CTRL1   4'h1
`define T1PWM_ADDR_CTRL2   4'h2
`define T1PWM_ADDR_DUTY    4'h3
`define T1PWM_ADDR_PSCNT   4'h4
`define T1PWM_ADDR_BUZZ    4'h5
`define T1PWM_ADDR_STATUS  4'h6
`define T1PWM_ADDR_MASK    4'h7

// timer_control_one fields
`define T1PWM_C1_EN        0
`define T1PWM_C1_RL        1
`define T1PWM_C1_OS        2
`define T1PWM_C1_ACTLOW    6
`define T1PWM_C1_OUTEN     7
`define T1PWM_C1_RDMASK    8'h07

// timer_control_two fields
`define T1PWM_C2_SEL_LSB   0
`define T1PWM_C2_PSDIS     3
`define T1PWM_C2_EDGE      4
`define T1PWM_C2_SRC       5
`define T1PWM_C2_RDMASK    8'h3F

// buzzer_control fields
`define T1PWM_BZ_EN        7

// interrupt status bits
`define T1PWM_IRQ_UNDER    0
`define T1PWM_IRQ_MATCH    1
`define T1PWM_IRQ_W        2

// reset values and counter limits
`define T1PWM_RST_C1       8'h00
`define T1PWM_RST_C2       8'h3F
`define T1PWM_RST_BZ       8'h0F
`define T1PWM_RST_PS       8'hFF
`define T1PWM_RST_BYTE     8'h00
`define T1PWM_TOP          8'hFF
`define T1PWM_ZERO         8'h00

`endif

// File: rtl/t1pwm_pkg.sv
// types shared by the timer/pulse/buzzer block
`default_nettype none

package t1pwm_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } t1pwm_bus_req_t;

    typedef enum logic [1:0] {
        T1PWM_IDLE = 2'b00,
        T1PWM_RUN  = 2'b01,
        T1PWM_DONE = 2'b10
    } t1pwm_state_t;

endpackage : t1pwm_pkg

`default_nettype wire

// File: rtl/t1pwm_edge.sv
// edge detector for synchronous input pins
`timescale 1ns/1ps
`default_nettype none

module t1pwm_edge #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         sys_rst,
    // sampled level and edges
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] prev_r;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prev_r <= '0;
        end else begin
            prev_r <= d;
        end
    end

    assign rise = d & ~prev_r;
    assign fall = ~d & prev_r;

endmodule : t1pwm_edge

`default_nettype wire

// File: rtl/t1pwm_prescale.sv
// eight-bit down-counting prescaler with selectable divide tap
`timescale 1ns/1ps
`include "t1pwm_cfg.svh"
`default_nettype none

module t1pwm_prescale (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // control
    input  wire logic       step,
    input  wire logic [2:0] sel,
    // state and divided tick
    output logic      [7:0] cnt_r,
    output logic            tick
);

    logic [7:0] low_mask;

    // sel 0 looks at one bit (1:2), sel 7 at all eight (1:256)
    assign low_mask = 8'hFF >> (3'h7 - sel);
    assign tick     = step && ((cnt_r & low_mask) == 8'h00);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_r <= `T1PWM_RST_PS;
        end else if (step) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

endmodule : t1pwm_prescale

`default_nettype wire

// File: rtl/t1pwm_core.sv
// eight-bit down timer with prescaler, pulse output and buzzer output
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "t1pwm_cfg.svh"
`default_nettype none

module t1pwm_core import t1pwm_pkg::*; (
    // clock and reset
    input  wire logic           clk_sys,
    input  wire logic           sys_rst,
    // register port
    input  wire t1pwm_bus_req_t bus_req,
    output logic [7:0]          rd_data,
    // external count clock
    input  wire logic           external_count_clock_pin,
    // port logic that owns the pin when the pulse is off
    input  wire logic           gpio_out,
    input  wire logic           gpio_oe,
    // pulse pin
    output logic                pulse_pin_out,
    output logic                pulse_pin_oe,
    // buzzer and interrupt
    output logic                buzzer_out,
    output logic                irq
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]   count_r;
    logic [7:0]   reload_r;
    logic [7:0]   ctrl1_r;
    logic [7:0]   ctrl2_r;
    logic [7:0]   duty_r;
    logic [7:0]   buzz_r;
    logic [`T1PWM_IRQ_W-1:0] status_r;
    logic [`T1PWM_IRQ_W-1:0] mask_r;
    logic [`T1PWM_IRQ_W-1:0] status_nxt;
    logic [`T1PWM_IRQ_W-1:0] events;
    logic [`T1PWM_IRQ_W-1:0] clr_bits;
    t1pwm_state_t state_r;
    t1pwm_state_t state_nxt;
    logic         pwm_act_r;
    logic [7:0]   ps_cnt;
    logic         ps_tick;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    logic w_count;
    logic w_ctrl1;
    logic w_ctrl2;
    logic w_duty;
    logic w_buzz;
    logic w_status;
    logic w_mask;

    assign w_count  = bus_req.wr && (bus_req.addr == `T1PWM_ADDR_COUNT);
    assign w_ctrl1  = bus_req.wr && (bus_req.addr == `T1PWM_ADDR_CTRL1);
    assign w_ctrl2  = bus_req.wr && (bus_req.addr == `T1PWM_ADDR_CTRL2);
    assign w_duty   = bus_req.wr && (bus_req.addr == `T1PWM_ADDR_DUTY);
    assign w_buzz   = bus_req.wr && (bus_req.addr == `T1PWM_ADDR_BUZZ);
    assign w_status = bus_req.wr && (bus_req.addr == `T1PWM_ADDR_STATUS);
    assign w_mask   = bus_req.wr && (bus_req.addr == `T1PWM_ADDR_MASK);

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    logic       timer_enable_bit;
    logic       reload_select;
    logic       one_shot_select;
    logic       pulse_active_low;
    logic       pulse_output_enable;
    logic [2:0] prescale_ratio;
    logic       prescale_disable_n;
    logic       ext_edge_select;
    logic       count_clock_source;
    logic       buzzer_enable;
    logic [3:0] buzzer_freq_select;

    assign timer_enable_bit    = ctrl1_r[`T1PWM_C1_EN];
    assign reload_select       = ctrl1_r[`T1PWM_C1_RL];
    assign one_shot_select     = ctrl1_r[`T1PWM_C1_OS];
    assign pulse_active_low    = ctrl1_r[`T1PWM_C1_ACTLOW];
    assign pulse_output_enable = ctrl1_r[`T1PWM_C1_OUTEN];
    assign prescale_ratio      = ctrl2_r[`T1PWM_C2_SEL_LSB +: 3];
    assign prescale_disable_n  = ctrl2_r[`T1PWM_C2_PSDIS];
    assign ext_edge_select     = ctrl2_r[`T1PWM_C2_EDGE];
    assign count_clock_source  = ctrl2_r[`T1PWM_C2_SRC];
    assign buzzer_enable       = buzz_r[`T1PWM_BZ_EN];
    assign buzzer_freq_select  = buzz_r[3:0];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl1_r <= `T1PWM_RST_C1;
            ctrl2_r <= `T1PWM_RST_C2;
            duty_r  <= `T1PWM_RST_BYTE;
            buzz_r  <= `T1PWM_RST_BZ;
            mask_r  <= '0;
        end else begin
            if (w_ctrl1) begin
                ctrl1_r <= bus_req.wdata;
            end
            if (w_ctrl2) begin
                // ratio changes are only safe with the prescaler off; not enforced
                ctrl2_r <= bus_req.wdata & `T1PWM_C2_RDMASK;
            end
            if (w_duty) begin
                duty_r <= bus_req.wdata;
            end
            if (w_buzz) begin
                buzz_r <= bus_req.wdata;
            end
            if (w_mask) begin
                mask_r <= bus_req.wdata[`T1PWM_IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // count source and prescaler
    // ------------------------------------------------------------
    logic ext_rise;
    logic ext_fall;
    logic src_step;
    logic run;
    logic tmr_tick;
    logic underflow;

    t1pwm_edge #(
        .W (1)
    ) u_ext_edge (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .d       (external_count_clock_pin),
        .rise    (ext_rise),
        .fall    (ext_fall)
    );

    // instruction clock ticks every cycle; external pin on the chosen edge
    assign src_step = count_clock_source
                    ? (ext_edge_select ? ext_fall : ext_rise)
                    : 1'b1;

    assign run = timer_enable_bit && (state_r == T1PWM_RUN);

    t1pwm_prescale u_prescale (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .step    (run && src_step && !prescale_disable_n),
        .sel     (prescale_ratio),
        .cnt_r   (ps_cnt),
        .tick    (ps_tick)
    );

    assign tmr_tick  = run && (prescale_disable_n ? src_step : ps_tick);
    // a software write to the count takes priority over a tick
    assign underflow = tmr_tick && (count_r == `T1PWM_ZERO) && !w_count;

    // ------------------------------------------------------------
    // run state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            T1PWM_IDLE: begin
                if (timer_enable_bit) begin
                    state_nxt = T1PWM_RUN;
                end
            end
            T1PWM_RUN: begin
                if (!timer_enable_bit) begin
                    state_nxt = T1PWM_IDLE;
                end else if (underflow && one_shot_select) begin
                    state_nxt = T1PWM_DONE;
                end
            end
            T1PWM_DONE: begin
                if (!timer_enable_bit) begin
                    state_nxt = T1PWM_IDLE;
                end else if (w_count) begin
                    state_nxt = T1PWM_RUN;
                end
            end
            default: begin
                state_nxt = T1PWM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= T1PWM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // counter and reload
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count_r  <= `T1PWM_RST_BYTE;
            reload_r <= `T1PWM_RST_BYTE;
        end else if (w_count) begin
            count_r  <= bus_req.wdata;
            reload_r <= bus_req.wdata;
        end else if (underflow) begin
            if (one_shot_select) begin
                count_r <= `T1PWM_ZERO;
            end else if (reload_select) begin
                count_r <= reload_r;
            end else begin
                count_r <= `T1PWM_TOP;
            end
        end else if (tmr_tick) begin
            count_r <= count_r - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // pulse generator
    // ------------------------------------------------------------
    logic match;

    assign match = run && (count_r == duty_r);

    // period is set by the reload value when reload_select is set, duty by the compare point
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pwm_act_r <= 1'b0;
        end else if ((state_r == T1PWM_IDLE) || underflow) begin
            pwm_act_r <= 1'b0;
        end else if (match) begin
            pwm_act_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pulse_pin_out <= 1'b0;
            pulse_pin_oe  <= 1'b0;
        end else if (pulse_output_enable) begin
            pulse_pin_out <= pwm_act_r ^ pulse_active_low;
            pulse_pin_oe  <= 1'b1;
        end else begin
            pulse_pin_out <= gpio_out;
            pulse_pin_oe  <= gpio_oe;
        end
    end

    // ------------------------------------------------------------
    // buzzer
    // ------------------------------------------------------------
    logic buzz_src;

    // prescaler bit k toggles at 1:2^(k+1) of the count source
    assign buzz_src = buzzer_freq_select[3] ? count_r[buzzer_freq_select[2:0]]
                                            : ps_cnt[buzzer_freq_select[2:0]];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            buzzer_out <= 1'b0;
        end else begin
            buzzer_out <= buzzer_enable && buzz_src;
        end
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    assign events[`T1PWM_IRQ_UNDER] = underflow;
    assign events[`T1PWM_IRQ_MATCH] = match && !pwm_act_r && !underflow;
    assign clr_bits   = w_status ? bus_req.wdata[`T1PWM_IRQ_W-1:0] : '0;
    // a new event in the clearing cycle survives
    assign status_nxt = (status_r & ~clr_bits) | events;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_r <= '0;
            irq      <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq      <= |(status_nxt & mask_r);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                `T1PWM_ADDR_COUNT:  rd_data <= count_r;
                `T1PWM_ADDR_CTRL1:  rd_data <= ctrl1_r & `T1PWM_C1_RDMASK;
                `T1PWM_ADDR_CTRL2:  rd_data <= ctrl2_r;
                `T1PWM_ADDR_PSCNT:  rd_data <= ps_cnt;
                `T1PWM_ADDR_STATUS: rd_data <= {6'h00, status_r};
                `T1PWM_ADDR_MASK:   rd_data <= {6'h00, mask_r};
                default:            rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_count_read:
        assert property (bus_req.rd && bus_req.addr == `T1PWM_ADDR_COUNT |=> rd_data == $past(count_r))
        else $error("count read does not return counter");

    a_count_write:
        assert property (w_count |=> count_r == $past(bus_req.wdata) && reload_r == $past(bus_req.wdata))
        else $error("count write did not load counter and reload");

    a_halt_hold:
        assert property (!timer_enable_bit && !w_count |=> $stable(count_r))
        else $error("counter moved while disabled");

    a_wrap_top:
        assert property (underflow && !one_shot_select && !reload_select |=> count_r == `T1PWM_TOP)
        else $error("non-stop wrap did not load FF");

    a_wrap_reload:
        assert property (underflow && !one_shot_select && reload_select |=> count_r == $past(reload_r))
        else $error("non-stop wrap did not load reload value");

    a_oneshot_stop:
        assert property (underflow && one_shot_select && timer_enable_bit && !w_ctrl1
                         |=> state_r == T1PWM_DONE && count_r == `T1PWM_ZERO ##1 count_r == `T1PWM_ZERO)
        else $error("one-shot did not stop at zero");

    a_duty_active:
        assert property (match && !underflow && state_r != T1PWM_IDLE |=> pwm_act_r ##1 pulse_pin_out ==
                         ($past(pulse_output_enable) ? $past(pwm_act_r) ^ $past(pulse_active_low) : $past(gpio_out)))
        else $error("pulse did not turn active on duty match");

    a_pin_polarity:
        assert property (pulse_output_enable |=> pulse_pin_oe && pulse_pin_out == ($past(pwm_act_r) ^ $past(pulse_active_low)))
        else $error("pulse pin level or enable wrong");

    a_buzz_off:
        assert property (!buzzer_enable && !w_buzz |=> !buzzer_out)
        else $error("buzzer active while disabled");

    a_underflow_irq:
        assert property (underflow && mask_r[`T1PWM_IRQ_UNDER] && !w_mask |=> irq && status_r[`T1PWM_IRQ_UNDER])
        else $error("underflow did not raise interrupt");

    c_oneshot_done:
        cover property (underflow && one_shot_select ##1 state_r == T1PWM_DONE);

    c_reload_wrap:
        cover property (underflow && reload_select && !one_shot_select);

    c_pulse_active:
        cover property (pulse_output_enable && pwm_act_r ##1 pulse_pin_oe);

    c_buzzer_on:
        cover property (buzzer_enable && buzzer_freq_select[3] ##1 buzzer_out);

endmodule : t1pwm_core

`default_nettype wire

// File: bench/t1pwm_core_tb.sv
// self-checking bench for the timer, pulse and buzzer block
`timescale 1ns/1ps
`default_nettype none
`include "t1pwm_cfg.svh"

module t1pwm_core_tb import t1pwm_pkg::*;;
    logic           clk_sys;
    logic           sys_rst;
    t1pwm_bus_req_t bus_req;
    logic [7:0]     rd_data;
    logic           ext_pin;
    logic           gpio_out;
    logic           gpio_oe;
    logic           pin_out;
    logic           pin_oe;
    logic           buzzer_out;
    logic           irq;
    int             err_count;
    int             tests_run;

    t1pwm_core dut_u (
        .clk_sys                  (clk_sys),
        .sys_rst                  (sys_rst),
        .bus_req                  (bus_req),
        .rd_data                  (rd_data),
        .external_count_clock_pin (ext_pin),
        .gpio_out                 (gpio_out),
        .gpio_oe                  (gpio_oe),
        .pulse_pin_out            (pin_out),
        .pulse_pin_oe             (pin_oe),
        .buzzer_out               (buzzer_out),
        .irq                      (irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // bus cycles and checks
    // ------------------------------------------------------------
    task automatic ok(input logic good, input string m);
        tests_run++;
        if (good !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : ok

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    // idle cycle after each strobe keeps every drive to one per time step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_req <= '{a, d, 1'b1, 1'b0};
        tick(1);
        bus_req <= '0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        tick(1);
        bus_req <= '0;
        // read data stand for this one cycle; take them mid-cycle
        @(negedge clk_sys);
        d = rd_data;
        tick(1);
    endtask : rd

    task automatic measure(input int n, output int hi, output int tg);
        logic prev;
        hi = 0;
        tg = 0;
        @(negedge clk_sys);
        prev = buzzer_out;
        repeat (n) begin
            tick(1);
            @(negedge clk_sys);
            if (pin_out === 1'b1) hi++;
            if (buzzer_out !== prev) tg++;
            prev = buzzer_out;
        end
        tick(1);
    endtask : measure

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [3:0] a[6] = '{`T1PWM_ADDR_CTRL1, `T1PWM_ADDR_CTRL2, `T1PWM_ADDR_PSCNT,
                             `T1PWM_ADDR_DUTY, `T1PWM_ADDR_BUZZ, 4'h9};
        logic [7:0] e[6] = '{8'h00, 8'h3F, 8'hFF, 8'h00, 8'h00, 8'h00};
        logic [7:0] d;
        ok(irq === 1'b0 && buzzer_out === 1'b0, "outputs after reset");
        wr(`T1PWM_ADDR_DUTY, 8'h55);
        wr(`T1PWM_ADDR_PSCNT, 8'h12);
        for (int i = 0; i < 6; i++) begin
            rd(a[i], d);
            ok(d === e[i], "register read");
        end
    endtask : t_reset

    task automatic t_count();
        logic [7:0] d;
        logic [7:0] d2;
        wr(`T1PWM_ADDR_CTRL2, 8'h08);
        wr(`T1PWM_ADDR_COUNT, 8'h10);
        rd(`T1PWM_ADDR_COUNT, d);
        ok(d === 8'h10, "count load");
        wr(`T1PWM_ADDR_CTRL1, 8'h01);
        tick(6);
        wr(`T1PWM_ADDR_CTRL1, 8'h00);
        rd(`T1PWM_ADDR_COUNT, d);
        tick(5);
        rd(`T1PWM_ADDR_COUNT, d2);
        ok(d < 8'h10 && d > 8'h04 && d2 === d, "count halt");
    endtask : t_count

    task automatic t_modes();
        logic [7:0] c[4] = '{8'h01, 8'h03, 8'h05, 8'h07};
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            wr(`T1PWM_ADDR_CTRL1, 8'h00);
            wr(`T1PWM_ADDR_COUNT, 8'h03);
            wr(`T1PWM_ADDR_CTRL1, c[i]);
            tick(20);
            wr(`T1PWM_ADDR_CTRL1, 8'h00);
            rd(`T1PWM_ADDR_COUNT, d);
            if (i == 0) ok(d > 8'h03, "wrap to top");
            else if (i == 1) ok(d <= 8'h03, "wrap to reload");
            else ok(d === 8'h00, "one-shot stop");
        end
    endtask : t_modes

    task automatic t_scale();
        logic [7:0] d;
        logic [7:0] dec;
        logic [7:0] s;
        for (int k = 0; k < 8; k++) begin
            wr(`T1PWM_ADDR_CTRL2, 8'h08 | 8'(k));
            wr(`T1PWM_ADDR_CTRL2, 8'(k));
            wr(`T1PWM_ADDR_COUNT, 8'hFF);
            wr(`T1PWM_ADDR_CTRL1, 8'h01);
            tick(8 << k);
            wr(`T1PWM_ADDR_CTRL1, 8'h00);
            // prescaler off again before the next ratio change
            wr(`T1PWM_ADDR_CTRL2, 8'h08 | 8'(k));
            rd(`T1PWM_ADDR_COUNT, d);
            dec = 8'hFF - d;
            ok(dec >= 8'h03 && dec <= 8'h05, "prescaled rate");
            if (k == 0) begin
                rd(`T1PWM_ADDR_PSCNT, d);
                s = 8'hFF - d;
                ok((s >> 1) === dec, "prescaler count");
            end
        end
    endtask : t_scale

    // four full pin pulses and a last rise: rising edges count five, falling four
    task automatic t_ext(input logic [7:0] c2, input logic [7:0] exp);
        logic [7:0] d;
        wr(`T1PWM_ADDR_CTRL2, c2);
        wr(`T1PWM_ADDR_COUNT, 8'h20);
        wr(`T1PWM_ADDR_CTRL1, 8'h01);
        tick(10);
        rd(`T1PWM_ADDR_COUNT, d);
        ok(d === 8'h20, "no count without pin edge");
        repeat (4) begin
            ext_pin <= 1'b1;
            tick(3);
            ext_pin <= 1'b0;
            tick(3);
        end
        ext_pin <= 1'b1;
        tick(3);
        wr(`T1PWM_ADDR_CTRL1, 8'h00);
        rd(`T1PWM_ADDR_COUNT, d);
        ok(d === exp, "pin edge count");
        ext_pin <= 1'b0;
        tick(3);
    endtask : t_ext

    task automatic t_pulse(input logic [7:0] rl, input logic [7:0] du, input logic [7:0] c1, input int exp);
        int         hi;
        int         tg;
        logic [7:0] d;
        wr(`T1PWM_ADDR_CTRL1, 8'h00);
        wr(`T1PWM_ADDR_CTRL2, 8'h08);
        wr(`T1PWM_ADDR_COUNT, rl);
        wr(`T1PWM_ADDR_DUTY, du);
        wr(`T1PWM_ADDR_CTRL1, c1);
        // pin shows the enabled pulse one cycle after the control write
        @(negedge clk_sys);
        ok(pin_out === c1[6], "pulse idle at start");
        tick(10);
        measure(50, hi, tg);
        ok(hi === exp, "pulse high time");
        ok(pin_oe === 1'b1, "pulse drives pin");
        rd(`T1PWM_ADDR_STATUS, d);
        ok(d[`T1PWM_IRQ_MATCH] === 1'b1, "duty match event");
    endtask : t_pulse

    task automatic t_gpio();
        wr(`T1PWM_ADDR_CTRL1, 8'h03);
        gpio_out <= 1'b0;
        gpio_oe  <= 1'b1;
        tick(3);
        ok(pin_out === 1'b0 && pin_oe === 1'b1, "pin to port logic");
        gpio_out <= 1'b1;
        tick(3);
        ok(pin_out === 1'b1, "pin follows port value");
    endtask : t_gpio

    // prescaler at 1:2 so the counter steps every second clock
    task automatic t_buzz();
        logic [7:0] b[5] = '{8'h80, 8'h81, 8'h88, 8'h89, 8'h08};
        int         e[5] = '{40, 20, 20, 10, 0};
        int         hi;
        int         tg;
        wr(`T1PWM_ADDR_CTRL1, 8'h00);
        wr(`T1PWM_ADDR_CTRL2, 8'h00);
        wr(`T1PWM_ADDR_COUNT, 8'hFF);
        wr(`T1PWM_ADDR_CTRL1, 8'h01);
        for (int i = 0; i < 5; i++) begin
            wr(`T1PWM_ADDR_BUZZ, b[i]);
            tick(4);
            measure(40, hi, tg);
            ok(tg >= e[i] - 1 && tg <= e[i] + 1, "buzzer rate");
        end
        ok(buzzer_out === 1'b0, "buzzer off");
    endtask : t_buzz

    task automatic t_irq();
        logic [7:0] d;
        logic       a;
        wr(`T1PWM_ADDR_CTRL1, 8'h00);
        wr(`T1PWM_ADDR_STATUS, 8'h03);
        rd(`T1PWM_ADDR_STATUS, d);
        ok(d === 8'h00, "status cleared");
        wr(`T1PWM_ADDR_COUNT, 8'h02);
        wr(`T1PWM_ADDR_CTRL1, 8'h05);
        tick(10);
        rd(`T1PWM_ADDR_STATUS, d);
        ok(d[0] === 1'b1, "underflow sticky");
        wr(`T1PWM_ADDR_MASK, 8'h00);
        tick(2);
        a = irq;
        wr(`T1PWM_ADDR_MASK, 8'h03);
        tick(2);
        ok(a === 1'b0 && irq === 1'b1, "mask gates irq");
        wr(`T1PWM_ADDR_CTRL1, 8'h00);
        wr(`T1PWM_ADDR_STATUS, 8'h03);
        tick(2);
        rd(`T1PWM_ADDR_STATUS, d);
        ok(d === 8'h00 && irq === 1'b0, "irq cleared");
    endtask : t_irq

    // ------------------------------------------------------------
    // sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic end_of_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    initial begin
        sys_rst   = 1'b1;
        bus_req   = '0;
        ext_pin   = 1'b0;
        gpio_out  = 1'b1;
        gpio_oe   = 1'b0;
        err_count = 0;
        tests_run = 0;
        tick(20);
        sys_rst <= 1'b0;
        tick(1);
        t_reset();
        t_count();
        t_modes();
        t_scale();
        t_ext(8'h28, 8'h1B);
        t_ext(8'h38, 8'h1C);
        t_pulse(8'h04, 8'h02, 8'h83, 20);
        t_pulse(8'h04, 8'h02, 8'hC3, 30);
        t_pulse(8'h09, 8'h03, 8'h83, 15);
        t_gpio();
        t_buzz();
        t_irq();
        end_of_test();
    end

    // run needs about 3000 cycles; allow well over twice that
    initial begin
        #2_000_000;
        err_count++;
        end_of_test();
    end
endmodule : t1pwm_core_tb
`default_nettype wire
